// >>> design/tsp_pkg.sv
package tsp_pkg;
  // register byte offsets (AXI4-Lite, one word each)
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] TXSLOT_OFS = 8'h04;
  localparam logic [7:0] RXSLOT_OFS = 8'h08;
  localparam logic [7:0] TXDATA_OFS = 8'h0C;
  localparam logic [7:0] RXDATA_OFS = 8'h10;
  localparam logic [7:0] STATUS_OFS = 8'h14;
  // control field positions
  localparam int HWY_EN_BIT = 0;
  localparam int PIN17_SEL_BIT = 1;
  localparam int PIN21_SEL_BIT = 2;
  localparam int OUTA_EN_BIT = 3;
  localparam int OUTB_EN_BIT = 4;
  localparam int TXCLK_INV_BIT = 5;
  localparam int RXCLK_INV_BIT = 6;
  localparam int TX_INV_BIT = 7;
  localparam int TX_ORDER_BIT = 8;
  localparam int RX_INV_BIT = 9;
  localparam int RX_ORDER_BIT = 10;
  localparam int RX_SEL_BIT = 11;
  localparam int FS_POL_BIT = 12;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0040;
  localparam int CTRL_W = 13;
  // slot register: bit offset in [2:0], slot number in [10:3]
  localparam int SLOT_W = 11;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [2:0] LAST_BIT = 3'h7;

  typedef struct packed {
    logic dataA;
    logic dataAOe;
    logic pin17;
    logic pin17Oe;
  } tsp_txpins_t;

  typedef enum logic [2:0] {
    TSP_IDLE = 3'b001,
    TSP_SHIFT = 3'b010,
    TSP_DONE = 3'b100
  } tsp_state_t;
endpackage

// >>> design/tsp_port.sv
module tsp_port (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic transmitBitClock,
  input wire logic pin21In,
  input wire logic receiveDataInA,
  input wire logic frameSync,
  output tsp_pkg::tsp_txpins_t txPins
);
  import tsp_pkg::*;

  logic [CTRL_W-1:0] ctrl_reg;
  logic [SLOT_W-1:0] txSlot_reg;
  logic [SLOT_W-1:0] rxSlot_reg;
  logic [7:0] txData_reg;
  logic [7:0] rxData_reg;
  logic txPend_reg;
  logic rxFull_reg;
  logic [3:0] sync1_reg;
  logic [3:0] sync2_reg;
  logic [3:0] prev_reg;
  logic [SLOT_W-1:0] txCnt_reg;
  logic [SLOT_W-1:0] rxCnt_reg;
  logic txFramed_reg;
  logic rxFramed_reg;
  tsp_state_t txState_reg;
  tsp_state_t rxState_reg;
  logic [2:0] txIdx_reg;
  logic [2:0] rxIdx_reg;
  logic [7:0] txShift_reg;
  logic [7:0] rxShift_reg;
  logic txBit_reg;
  logic txActive_reg;
  logic awSeen_reg;
  logic wSeen_reg;
  logic [7:0] awAddr_reg;
  logic [31:0] wData_reg;
  logic [3:0] wStrb_reg;

  // bit position picked by the order flag: lsb-first or msb-first
  function automatic logic [2:0] bitPos(input logic msbFirst, input logic [2:0] idx);
    bitPos = msbFirst ? (LAST_BIT - idx) : idx;
  endfunction

  // decode a word address to a known register
  function automatic logic isMapped(input logic [7:0] a);
    isMapped = (a == CTRL_OFS) || (a == TXSLOT_OFS) || (a == RXSLOT_OFS) ||
      (a == TXDATA_OFS) || (a == RXDATA_OFS) || (a == STATUS_OFS);
  endfunction

  // every pin from outside passes two flops before use
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sync1_reg <= 4'h0;
      sync2_reg <= 4'h0;
      prev_reg <= 4'h0;
    end else begin
      sync1_reg <= {frameSync, receiveDataInA, pin21In, transmitBitClock};
      sync2_reg <= sync1_reg;
      prev_reg <= sync2_reg;
    end
  end

  logic txClkS;
  logic pin21S;
  logic rxInA;
  logic fsS;
  logic txRise;
  logic txFall;
  logic launchEdge;
  logic rxClkRise;
  logic rxClkFall;
  logic sampleEdge;
  logic fsEdge;
  logic rxRaw;
  logic rxBit;
  assign txClkS = sync2_reg[0];
  assign pin21S = sync2_reg[1];
  assign rxInA = sync2_reg[2];
  assign fsS = sync2_reg[3];
  assign txRise = txClkS & ~prev_reg[0];
  assign txFall = ~txClkS & prev_reg[0];
  // transmit launch edge: falling by default
  assign launchEdge = ctrl_reg[TXCLK_INV_BIT] ? txRise : txFall;
  // pin 21 doubles as data B, then receive borrows the transmit clock
  assign rxClkRise = ctrl_reg[PIN21_SEL_BIT] ? txRise : (pin21S & ~prev_reg[1]);
  assign rxClkFall = ctrl_reg[PIN21_SEL_BIT] ? txFall : (~pin21S & prev_reg[1]);
  assign sampleEdge = ctrl_reg[RXCLK_INV_BIT] ? rxClkRise : rxClkFall;
  // frame start: active level picked by polarity, dropped when highway off
  assign fsEdge = ctrl_reg[HWY_EN_BIT] &&
    ((ctrl_reg[FS_POL_BIT] ? ~fsS : fsS) && !(ctrl_reg[FS_POL_BIT] ? ~prev_reg[3] : prev_reg[3]));
  // input B only exists when pin 21 is configured as data
  assign rxRaw = (ctrl_reg[RX_SEL_BIT] && ctrl_reg[PIN21_SEL_BIT]) ? pin21S : rxInA;
  assign rxBit = rxRaw ^ ctrl_reg[RX_INV_BIT];

  // bit counters since frame start, one per direction
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      txCnt_reg <= '0;
      txFramed_reg <= 1'b0;
    end else if (fsEdge) begin
      txCnt_reg <= '0;
      txFramed_reg <= 1'b1;
    end else if (launchEdge && txFramed_reg) begin
      txCnt_reg <= txCnt_reg + 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rxCnt_reg <= '0;
      rxFramed_reg <= 1'b0;
    end else if (fsEdge) begin
      rxCnt_reg <= '0;
      rxFramed_reg <= 1'b1;
    end else if (sampleEdge && rxFramed_reg) begin
      rxCnt_reg <= rxCnt_reg + 1'b1;
    end
  end

  // transmit shifter: starts on the programmed slot, eight launches long
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      txState_reg <= TSP_IDLE;
      txIdx_reg <= 3'h0;
      txShift_reg <= 8'h00;
      txBit_reg <= 1'b0;
      txActive_reg <= 1'b0;
    end else begin
      case (txState_reg)
        TSP_IDLE: begin
          txActive_reg <= 1'b0;
          if (launchEdge && txFramed_reg && txCnt_reg == txSlot_reg && !fsEdge) begin
            txShift_reg <= txPend_reg ? txData_reg : 8'hFF;
            txBit_reg <= (txPend_reg ? txData_reg[bitPos(ctrl_reg[TX_ORDER_BIT], 3'h0)] : 1'b1)
              ^ ctrl_reg[TX_INV_BIT];
            txIdx_reg <= 3'h1;
            txActive_reg <= 1'b1;
            txState_reg <= TSP_SHIFT;
          end
        end
        TSP_SHIFT: begin
          // a new frame sync cuts a byte whose closing edge never came, so no line floats driven
          if (fsEdge || (launchEdge && txIdx_reg == 3'h0)) begin
            txActive_reg <= 1'b0;
            txState_reg <= TSP_DONE;
          end else if (launchEdge) begin
            txBit_reg <= txShift_reg[bitPos(ctrl_reg[TX_ORDER_BIT], txIdx_reg)] ^ ctrl_reg[TX_INV_BIT];
            txIdx_reg <= txIdx_reg + 3'h1;
          end
        end
        TSP_DONE: begin
          txState_reg <= TSP_IDLE;
        end
        default: begin
          txState_reg <= TSP_IDLE;
        end
      endcase
    end
  end

  // receive shifter mirrors the transmit side on the sample edge
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rxState_reg <= TSP_IDLE;
      rxIdx_reg <= 3'h0;
      rxShift_reg <= 8'h00;
    end else begin
      case (rxState_reg)
        TSP_IDLE: begin
          if (sampleEdge && rxFramed_reg && rxCnt_reg == rxSlot_reg && !fsEdge) begin
            rxShift_reg[bitPos(ctrl_reg[RX_ORDER_BIT], 3'h0)] <= rxBit;
            rxIdx_reg <= 3'h1;
            rxState_reg <= TSP_SHIFT;
          end
        end
        TSP_SHIFT: begin
          if (sampleEdge) begin
            rxShift_reg[bitPos(ctrl_reg[RX_ORDER_BIT], rxIdx_reg)] <= rxBit;
            rxIdx_reg <= rxIdx_reg + 3'h1;
            if (rxIdx_reg == LAST_BIT) begin
              rxState_reg <= TSP_DONE;
            end
          end
        end
        TSP_DONE: begin
          rxState_reg <= TSP_IDLE;
        end
        default: begin
          rxState_reg <= TSP_IDLE;
        end
      endcase
    end
  end

  // pin drive: strobe mode overrides out B and keeps pin 17 driven, idle data lines float
  logic outAOn;
  logic outBOn;
  assign outAOn = ctrl_reg[OUTA_EN_BIT] && txActive_reg;
  assign outBOn = ctrl_reg[OUTB_EN_BIT] && !ctrl_reg[PIN17_SEL_BIT] && txActive_reg;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      txPins <= '0;
    end else begin
      txPins.dataA <= txBit_reg;
      txPins.dataAOe <= outAOn;
      if (ctrl_reg[PIN17_SEL_BIT]) begin
        txPins.pin17 <= ~txActive_reg;
        txPins.pin17Oe <= 1'b1;
      end else begin
        txPins.pin17 <= txBit_reg;
        txPins.pin17Oe <= outBOn;
      end
    end
  end

  // write channel: address and data taken in either order
  logic wrGo;
  assign s_axi_awready = !awSeen_reg && !s_axi_bvalid;
  assign s_axi_wready = !wSeen_reg && !s_axi_bvalid;
  assign wrGo = awSeen_reg && wSeen_reg && !s_axi_bvalid;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      awSeen_reg <= 1'b0;
      wSeen_reg <= 1'b0;
      awAddr_reg <= 8'h00;
      wData_reg <= 32'h0000_0000;
      wStrb_reg <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awSeen_reg <= 1'b1;
        awAddr_reg <= {s_axi_awaddr[7:2], 2'h0};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wSeen_reg <= 1'b1;
        wData_reg <= s_axi_wdata;
        wStrb_reg <= s_axi_wstrb;
      end
      if (wrGo) begin
        awSeen_reg <= 1'b0;
        wSeen_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= isMapped(awAddr_reg) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // configuration registers; byte lanes 0 and 1 only carry bits
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg <= CTRL_RESET[CTRL_W-1:0];
      txSlot_reg <= '0;
      rxSlot_reg <= '0;
      txData_reg <= 8'h00;
    end else if (wrGo) begin
      if (awAddr_reg == CTRL_OFS) begin
        if (wStrb_reg[0]) ctrl_reg[7:0] <= wData_reg[7:0];
        if (wStrb_reg[1]) ctrl_reg[CTRL_W-1:8] <= wData_reg[CTRL_W-1:8];
      end
      if (awAddr_reg == TXSLOT_OFS) begin
        if (wStrb_reg[0]) txSlot_reg[7:0] <= wData_reg[7:0];
        if (wStrb_reg[1]) txSlot_reg[SLOT_W-1:8] <= wData_reg[SLOT_W-1:8];
      end
      if (awAddr_reg == RXSLOT_OFS) begin
        if (wStrb_reg[0]) rxSlot_reg[7:0] <= wData_reg[7:0];
        if (wStrb_reg[1]) rxSlot_reg[SLOT_W-1:8] <= wData_reg[SLOT_W-1:8];
      end
      if (awAddr_reg == TXDATA_OFS && wStrb_reg[0]) txData_reg <= wData_reg[7:0];
    end
  end

  // pending byte flags: a TXDATA write wins over a same-cycle transmit done, a receive done wins over a same-cycle RXDATA read
  logic txLoad;
  logic rxRead;
  assign txLoad = wrGo && awAddr_reg == TXDATA_OFS && wStrb_reg[0];
  assign rxRead = s_axi_arvalid && s_axi_arready && {s_axi_araddr[7:2], 2'h0} == RXDATA_OFS;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      txPend_reg <= 1'b0;
      rxFull_reg <= 1'b0;
      rxData_reg <= 8'h00;
    end else begin
      if (txLoad) begin
        txPend_reg <= 1'b1;
      end else if (txState_reg == TSP_DONE) begin
        txPend_reg <= 1'b0;
      end
      if (rxState_reg == TSP_DONE) begin
        rxFull_reg <= 1'b1;
        rxData_reg <= rxShift_reg;
      end else if (rxRead) begin
        rxFull_reg <= 1'b0;
      end
    end
  end

  // read channel: one read at a time, answer one cycle after address
  logic [31:0] rdWord;
  assign s_axi_arready = !s_axi_rvalid;
  always_comb begin
    rdWord = 32'h0000_0000;
    case ({s_axi_araddr[7:2], 2'h0})
      CTRL_OFS: rdWord[CTRL_W-1:0] = ctrl_reg;
      TXSLOT_OFS: rdWord[SLOT_W-1:0] = txSlot_reg;
      RXSLOT_OFS: rdWord[SLOT_W-1:0] = rxSlot_reg;
      TXDATA_OFS: rdWord[7:0] = txData_reg;
      RXDATA_OFS: rdWord[7:0] = rxData_reg;
      STATUS_OFS: rdWord[3:0] = {txActive_reg, rxFramed_reg, rxFull_reg, txPend_reg};
      default: rdWord = 32'h0000_0000;
    endcase
  end
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rdWord;
      s_axi_rresp <= isMapped({s_axi_araddr[7:2], 2'h0}) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule

// >>> verif/tsp_port_asserts.sv
module tsp_port_asserts (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire tsp_pkg::tsp_txpins_t txPins
);
  import tsp_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] addrSeen_reg;
  logic [12:0] dataSeen_reg;
  logic [12:0] ctrl_reg;
  logic [2:0] settle_reg;
  logic [7:0] oeCnt_reg;
  logic quiet;
  // address and data as each handshake completes
  always_ff @(posedge clk_sys) begin
    if (s_axi_awvalid && s_axi_awready) addrSeen_reg <= s_axi_awaddr;
    if (s_axi_wvalid && s_axi_wready) dataSeen_reg <= s_axi_wdata[12:0];
  end
  // shadow control word; checks pause while a write ripples into the pins
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg <= CTRL_RESET[12:0];
      settle_reg <= 3'h0;
    end else begin
      if ($rose(s_axi_bvalid) && addrSeen_reg == CTRL_OFS) ctrl_reg <= dataSeen_reg;
      if (s_axi_awvalid || s_axi_wvalid || s_axi_bvalid) settle_reg <= 3'h6;
      else if (settle_reg != 3'h0) settle_reg <= settle_reg - 3'h1;
    end
  end
  // cycles the A output has been driven so far
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) oeCnt_reg <= 8'h00;
    else oeCnt_reg <= txPins.dataAOe ? oeCnt_reg + 8'h01 : 8'h00;
  end
  assign quiet = settle_reg == 3'h0;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  chk_read_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  // eight bit periods of 125 ns are 125 system clocks, give or take sampling
  chk_byte_length: assert property ($fell(txPins.dataAOe) |-> oeCnt_reg inside {[8'h7A:8'h80]})
    else $error("drive window not eight bits");
  chk_strobe_drive: assert property (quiet && ctrl_reg[PIN17_SEL_BIT] |-> txPins.pin17Oe)
    else $error("strobe pin not driven");
  chk_strobe_match: assert property (quiet && ctrl_reg[PIN17_SEL_BIT] && ctrl_reg[OUTA_EN_BIT]
    |-> txPins.pin17 == !txPins.dataAOe)
    else $error("strobe does not frame the bits");
  chk_out_b_off: assert property (quiet && !ctrl_reg[PIN17_SEL_BIT] && !ctrl_reg[OUTB_EN_BIT]
    |-> !txPins.pin17Oe)
    else $error("out B driven while disabled");
  chk_out_b_same: assert property (quiet && ctrl_reg[4:3] == 2'h3 && !ctrl_reg[PIN17_SEL_BIT]
    |-> txPins.pin17Oe == txPins.dataAOe && (!txPins.dataAOe || txPins.pin17 == txPins.dataA))
    else $error("outputs A and B differ");
  chk_out_a_off: assert property (quiet && !ctrl_reg[OUTA_EN_BIT] |-> !txPins.dataAOe)
    else $error("out A driven while disabled");
  cov_frame: cover property ($rose(txPins.dataAOe));
  cov_strobe: cover property (ctrl_reg[PIN17_SEL_BIT] && !txPins.pin17);
  cov_read: cover property (s_axi_rvalid);
endmodule

bind tsp_port tsp_port_asserts chk_u (.clk_sys, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .txPins);

// >>> verif/tsp_hwy_model.sv
module tsp_hwy_model (
  output logic bitClk,
  output logic frameSync,
  output logic rxA,
  output logic rxB
);
  timeunit 1ns;
  timeprecision 100ps;
  // clock rests high between frames
  initial begin
    bitClk = 1'b1;
    frameSync = 1'b0;
    rxA = 1'b0;
    rxB = 1'b1;
  end
  // one frame of 32 bits; the unselected line carries the inverse so a wrong pick shows
  task automatic run_frame(input logic [7:0] s, input int slot, input logic useB);
    int k;
    logic b;
    #1.2; // keep every pin edge off the system clock edges
    frameSync = 1'b1;
    #62.5;
    for (k = 0; k < 32; k++) begin
      b = (k >= slot && k < slot + 8) ? s[k - slot] : 1'($urandom);
      bitClk = 1'b0;
      frameSync = 1'b0;
      rxA = useB ? !b : b;
      rxB = useB ? b : !b;
      #62.5;
      bitClk = 1'b1;
      #62.5;
    end
    rxA = !rxA; // no stale level after the frame
    rxB = !rxB;
  endtask
endmodule

// >>> verif/test_tsp_port.sv
module test_tsp_port;
  import tsp_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_sys, rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [7:0] s_axi_awaddr, s_axi_araddr, sh;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic bitClk, fsLine, rxA, rxB;
  logic [12:0] ctrl;
  tsp_txpins_t txPins;
  logic [33:0] rdQ[$];
  logic [1:0] wrQ[$];
  logic [7:0] txQ[$];
  int n_fail, total_checks, idx, nb, slotTx;

  always #4 clk_sys = ~clk_sys;

  tsp_port dut_u (.clk_sys, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .transmitBitClock(bitClk), .pin21In(rxB), .receiveDataInA(rxA),
    .frameSync(fsLine), .txPins);
  tsp_hwy_model hwy_u (.bitClk(bitClk), .frameSync(fsLine), .rxA(rxA), .rxB(rxB));

  task automatic cmp(input string nm, input logic [33:0] e, input logic [33:0] s);
    total_checks++;
    if (s !== e) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic finish_test();
    if (n_fail == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic stall();
    n_fail++;
    finish_test();
  endtask
  // address and data offered together, each dropped once taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e = RESP_OKAY);
    int k;
    wrQ.push_back(e);
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (k = 0; k < 40; k++) begin
      @(posedge clk_sys);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 1'b0;
    if (k == 40) stall();
  endtask
  task automatic axi_rd(input logic [7:0] a, input logic [33:0] e);
    int k;
    rdQ.push_back(e);
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (k = 0; k < 40; k++) begin
      @(posedge clk_sys);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    s_axi_rready <= 1'b0;
    if (k == 40) stall();
  endtask

  // read answers meet the oldest pending expectation
  always @(posedge clk_sys) begin
    if (s_axi_rvalid && s_axi_rready) cmp("rdata", rdQ.pop_front(), {s_axi_rresp, s_axi_rdata});
    if (s_axi_bvalid && s_axi_bready) cmp("bresp", 34'(wrQ.pop_front()), 34'(s_axi_bresp));
  end
  // count launch edges from frame sync, take driven bits on the other edge
  always @(posedge fsLine) begin
    idx = 0;
    nb = 0;
  end
  always @(bitClk) begin
    if (bitClk === ctrl[TXCLK_INV_BIT]) idx++;
    else if (ctrl[PIN17_SEL_BIT] ? txPins.pin17 === 1'b0 : (txPins.dataAOe | txPins.pin17Oe) === 1'b1) begin
      if (nb == 0) cmp("slot", 34'(slotTx), 34'(idx - 1));
      sh[nb] = txPins.dataAOe ? txPins.dataA : txPins.pin17; // B carries the byte while A is off
      nb++;
      if (nb == 8) cmp("txbyte", 34'(txQ.pop_front()), 34'(sh));
    end
  end

  initial begin
    int i, sr;
    logic [7:0] d, r;
    logic [31:0] cfg;
    clk_sys = 1'b0;
    rst_n = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    ctrl = CTRL_RESET[12:0];
    n_fail = 0;
    total_checks = 0;
    void'($urandom(58579));
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    axi_rd(CTRL_OFS, {RESP_OKAY, CTRL_RESET});
    axi_rd(8'h1C, {RESP_SLVERR, 32'h0});
    axi_wr(8'h1C, 32'hFFFF_FFFF, RESP_SLVERR);
    axi_rd(CTRL_OFS, {RESP_OKAY, CTRL_RESET});
    // strobe mode on half the frames overrides the B enable, last frame launches on rising
    for (i = 0; i < 8; i++) begin
      cfg = $urandom;
      d = 8'($urandom);
      // the closing launch of the last bit must still fall inside the 32-bit frame
      slotTx = $urandom_range(23);
      sr = $urandom_range(24);
      ctrl = 13'h5D | {1'b0, cfg[11:9], i[1], i[0], 5'h0, i[2], 1'b0};
      ctrl[TXCLK_INV_BIT] = (i == 7);
      // random receive edge; out A off in one frame, out B off in another, strobe frames keep A on
      ctrl[RXCLK_INV_BIT] = cfg[RXCLK_INV_BIT];
      ctrl[OUTA_EN_BIT] = (i != 1);
      ctrl[OUTB_EN_BIT] = (i != 2);
      axi_wr(TXSLOT_OFS, 32'(slotTx));
      axi_wr(RXSLOT_OFS, 32'(sr));
      axi_wr(CTRL_OFS, {19'h0, ctrl});
      axi_wr(TXDATA_OFS, {24'h0, d});
      r = ctrl[TX_ORDER_BIT] ? {<<{d}} : d;
      txQ.push_back(ctrl[TX_INV_BIT] ? ~r : r);
      r = 8'($urandom);
      hwy_u.run_frame(r, sr, ctrl[RX_SEL_BIT]);
      repeat (8) @(posedge clk_sys);
      if (!ctrl[TXCLK_INV_BIT]) begin
        r = ctrl[RX_ORDER_BIT] ? {<<{r}} : r;
        axi_rd(RXDATA_OFS, {RESP_OKAY, 24'h0, ctrl[RX_INV_BIT] ? ~r : r});
      end
    end
    cmp("pending", 34'h0, 34'(txQ.size()));
    finish_test();
  end
endmodule
